// File: rtl/cpst_pkg.sv
/*
  Package of the programmer state file: register map, status word layout,
  sizes, operand types and addressing modes.
  Assumes a single 250 MHz clock and an AHB-Lite register window.
*/
package cpst_pkg;
  // ************************************************************
  // Sizes
  // ************************************************************
  localparam int CPST_NREG = 17;
  localparam int CPST_RIDX_W = 5;
  localparam logic [4:0] CPST_SUP_PTR_IDX = 5'h10;
  localparam logic [4:0] CPST_USR_PTR_IDX = 5'h0f;
  localparam logic [4:0] CPST_ACT_PTR_IDX = 5'h0f;
  localparam int CPST_ADDR_SMALL_W = 20;
  localparam int CPST_ADDR_LARGE_W = 22;
  localparam logic [31:0] CPST_REG_RESET = 32'h0000_0000;
  localparam logic [31:0] CPST_PC_RESET = 32'h0000_0000;
  localparam logic [15:0] CPST_SW_RESET = 16'h2700;

  // ************************************************************
  // Status word bit positions
  // ************************************************************
  localparam int CPST_SW_C = 0;
  localparam int CPST_SW_V = 1;
  localparam int CPST_SW_Z = 2;
  localparam int CPST_SW_N = 3;
  localparam int CPST_SW_X = 4;
  localparam int CPST_SW_MASK_LO = 8;
  localparam int CPST_SW_S = 13;
  localparam int CPST_SW_T = 15;
  localparam logic [15:0] CPST_SW_USER_BITS = 16'h001f;
  localparam logic [15:0] CPST_SW_SYS_BITS = 16'ha700;

  // ************************************************************
  // Register window byte offsets
  // ************************************************************
  localparam logic [7:0] CPST_OFS_GREG = 8'h00;
  localparam logic [7:0] CPST_OFS_PC = 8'h44;
  localparam logic [7:0] CPST_OFS_SW = 8'h48;
  localparam logic [7:0] CPST_OFS_ACT = 8'h4c;
  localparam logic [7:0] CPST_OFS_IRQ = 8'h50;
  localparam logic [7:0] CPST_OFS_CFG = 8'h54;

  // ************************************************************
  // Operand sizes, types and addressing modes
  // ************************************************************
  typedef enum logic [1:0] {CPST_SZ_BYTE, CPST_SZ_WORD, CPST_SZ_LONG} cpst_size_t;
  typedef enum logic [2:0] {
    CPST_DT_BIT, CPST_DT_BCD, CPST_DT_BYTE, CPST_DT_WORD, CPST_DT_LONG
  } cpst_dtype_t;
  typedef enum logic [3:0] {
    CPST_AM_DREG, CPST_AM_AREG, CPST_AM_IND, CPST_AM_POSTINC, CPST_AM_PREDEC,
    CPST_AM_DISP, CPST_AM_INDEX, CPST_AM_ABS_W, CPST_AM_ABS_L, CPST_AM_PC_DISP,
    CPST_AM_PC_INDEX, CPST_AM_IMM, CPST_AM_QUICK, CPST_AM_IMPLIED
  } cpst_amode_t;
endpackage

// File: rtl/cpst_ea_if.sv
/*
  Interface carrying one effective address request between the state file
  and its address calculator.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface cpst_ea_if;
  import cpst_pkg::*;
  cpst_amode_t mode;
  cpst_size_t size;
  logic [31:0] base;
  logic [31:0] index;
  logic index_long;
  logic [15:0] disp;
  logic [31:0] pc;
  logic [31:0] ext;
  logic large_cfg;
  logic [31:0] addr;
  logic [31:0] base_new;
  logic base_wr;
  modport calc (input mode, size, base, index, index_long, disp, pc, ext, large_cfg,
    output addr, base_new, base_wr);
  modport core (output mode, size, base, index, index_long, disp, pc, ext, large_cfg,
    input addr, base_new, base_wr);
endinterface

// File: rtl/cpst_ea_calc.sv
/*
  Effective address arithmetic for the nine memory addressing modes; the other five give address zero.
  Assumes registered inputs from the state file; purely combinational.
*/
`timescale 1ns/1ps
module cpst_ea_calc (
  cpst_ea_if.calc ea
);
  import cpst_pkg::*;
  logic [31:0] step;
  logic [31:0] idx;
  logic [31:0] d8;
  logic [31:0] d16;
  logic [31:0] raw;

  always_comb begin
    case (ea.size)
      CPST_SZ_BYTE: step = 32'h0000_0001;
      CPST_SZ_WORD: step = 32'h0000_0002;
      default: step = 32'h0000_0004;
    endcase
    // Index register word or long
    idx = ea.index_long ? ea.index : {{16{ea.index[15]}}, ea.index[15:0]};
    d8 = {{24{ea.disp[7]}}, ea.disp[7:0]};
    d16 = {{16{ea.disp[15]}}, ea.disp};
  end

  always_comb begin
    raw = 32'h0000_0000;
    ea.base_new = ea.base;
    ea.base_wr = 1'b0;
    case (ea.mode)
      CPST_AM_IND: raw = ea.base;
      CPST_AM_POSTINC: begin
        raw = ea.base;
        ea.base_new = ea.base + step;
        ea.base_wr = 1'b1;
      end
      CPST_AM_PREDEC: begin
        raw = ea.base - step;
        ea.base_new = ea.base - step;
        ea.base_wr = 1'b1;
      end
      CPST_AM_DISP: raw = ea.base + d16;
      CPST_AM_INDEX: raw = ea.base + idx + d8;
      CPST_AM_ABS_W: raw = d16;
      CPST_AM_ABS_L: raw = ea.ext;
      CPST_AM_PC_DISP: raw = ea.pc + d16;
      CPST_AM_PC_INDEX: raw = ea.pc + idx + d8;
      default: raw = 32'h0000_0000;
    endcase
    // Address lines in use for each configuration
    ea.addr = ea.large_cfg ? {10'h000, raw[CPST_ADDR_LARGE_W-1:0]}
                           : {12'h000, raw[CPST_ADDR_SMALL_W-1:0]};
  end

endmodule

// File: rtl/cpst_state_file.sv
/*
  Programmer-visible state of the processor: seventeen general registers,
  program counter and status word, with banked stack pointers.
  Assumes a single AHB-Lite master and one 250 MHz clock.
*/
// The implementer's own choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
module cpst_state_file
  import cpst_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Core write port
  input wire logic core_we,
  input wire logic [4:0] core_idx,
  input wire cpst_pkg::cpst_size_t core_size,
  input wire logic [31:0] core_wdata,
  // Core operand read and bit or digit extract
  input wire logic [4:0] core_ridx,
  input wire cpst_pkg::cpst_dtype_t core_dtype,
  input wire logic [4:0] core_sel,
  output logic [31:0] core_operand,
  // Condition code and program counter update
  input wire logic cc_we,
  input wire logic [4:0] cc_in,
  input wire logic pc_we,
  input wire logic [31:0] pc_in,
  // Address calculation
  input wire cpst_pkg::cpst_amode_t ea_mode,
  input wire logic [4:0] ea_base_idx,
  input wire logic [4:0] ea_index_idx,
  input wire logic ea_index_long,
  input wire logic [15:0] ea_disp,
  input wire logic [31:0] ea_ext,
  input wire logic ea_go,
  output logic [31:0] ea_addr,
  // Interrupt level
  input wire logic [2:0] irq_level,
  output logic irq_take,
  // State out
  output logic [31:0] pc,
  output logic [15:0] status_word,
  output logic [31:0] active_stack_pointer
);
  import cpst_pkg::*;

  // ************************************************************
  // Storage
  // ************************************************************
  logic [31:0] gregs_q [CPST_NREG];
  logic [31:0] pc_q;
  logic [15:0] sw_q;
  logic large_cfg_q;
  logic [2:0] irq_lvl_q;
  logic [2:0] irq_sync1_q;
  logic supervisor;
  logic [2:0] prio_mask;
  cpst_ea_if ea();

  assign supervisor = sw_q[CPST_SW_S];
  assign prio_mask = sw_q[CPST_SW_MASK_LO +: 3];

  // Stack pointer bank select
  function automatic logic [4:0] bank(input logic [4:0] idx, input logic s);
    logic [4:0] r;
    r = idx;
    if (idx == CPST_ACT_PTR_IDX && s) begin
      r = CPST_SUP_PTR_IDX;
    end
    return r;
  endfunction

  // ************************************************************
  // AHB-Lite slave
  // ************************************************************
  logic ap_valid_q;
  logic ap_write_q;
  logic [7:0] ap_addr_q;
  logic bus_we;
  logic [4:0] bus_gidx;
  logic bus_greg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid_q <= 1'b0;
      ap_write_q <= 1'b0;
      ap_addr_q <= 8'h00;
    end else if (hready) begin
      ap_valid_q <= hsel && htrans[1];
      ap_write_q <= hwrite;
      ap_addr_q <= haddr[7:0];
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign bus_we = ap_valid_q && ap_write_q;
  assign bus_gidx = ap_addr_q[6:2];
  assign bus_greg = ap_addr_q < CPST_OFS_PC;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hsel && htrans[1] && !hwrite && hready) begin
      if (haddr[7:0] < CPST_OFS_PC) begin
        hrdata <= gregs_q[haddr[6:2]];
      end else begin
        case (haddr[7:0])
          CPST_OFS_PC: hrdata <= pc_q;
          CPST_OFS_SW: hrdata <= {16'h0000, sw_q};
          CPST_OFS_ACT: hrdata <= gregs_q[bank(CPST_ACT_PTR_IDX, supervisor)];
          CPST_OFS_IRQ: hrdata <= {28'h0000000, irq_take, irq_lvl_q};
          CPST_OFS_CFG: hrdata <= {31'h00000000, large_cfg_q};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      large_cfg_q <= 1'b0;
    end else if (bus_we && ap_addr_q == CPST_OFS_CFG) begin
      large_cfg_q <= hwdata[0];
    end
  end

  // ************************************************************
  // General registers
  // ************************************************************
  logic [4:0] wr_idx;
  logic [31:0] wr_old;
  logic [31:0] wr_new;
  logic wr_ok;

  always_comb begin
    wr_idx = bank(core_idx, supervisor);
    wr_old = gregs_q[wr_idx];
    wr_new = core_wdata;
    case (core_size)
      CPST_SZ_BYTE: wr_new = {wr_old[31:8], core_wdata[7:0]};
      CPST_SZ_WORD: begin
        // Word writes to address registers sign extend
        if (wr_idx < 5'h08) begin
          wr_new = {wr_old[31:16], core_wdata[15:0]};
        end else begin
          wr_new = {{16{core_wdata[15]}}, core_wdata[15:0]};
        end
      end
      default: wr_new = core_wdata;
    endcase
    // Byte size not allowed on address registers
    wr_ok = core_we && !(core_size == CPST_SZ_BYTE && wr_idx >= 5'h08);
  end

  genvar gi;
  generate
    for (gi = 0; gi < CPST_NREG; gi++) begin : g_reg
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          gregs_q[gi] <= CPST_REG_RESET;
        end else if (ea.base_wr && ea_go && bank(ea_base_idx, supervisor) == gi
                     && (gi != CPST_SUP_PTR_IDX || supervisor)) begin
          gregs_q[gi] <= ea.base_new;
        end else if (wr_ok && wr_idx == gi && (gi != CPST_SUP_PTR_IDX || supervisor)) begin
          gregs_q[gi] <= wr_new;
        end else if (bus_we && bus_greg && bus_gidx == gi
                     && (gi != CPST_SUP_PTR_IDX || supervisor)) begin
          gregs_q[gi] <= hwdata;
        end
      end
    end
  endgenerate

  // ************************************************************
  // Program counter and status word
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pc_q <= CPST_PC_RESET;
    end else if (pc_we) begin
      pc_q <= pc_in;
    end else if (bus_we && ap_addr_q == CPST_OFS_PC) begin
      pc_q <= hwdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sw_q <= CPST_SW_RESET;
    end else if (bus_we && ap_addr_q == CPST_OFS_SW) begin
      // User state may only write the user byte
      if (supervisor) begin
        sw_q <= hwdata[15:0] & (CPST_SW_USER_BITS | CPST_SW_SYS_BITS);
      end else begin
        sw_q <= (sw_q & ~CPST_SW_USER_BITS) | (hwdata[15:0] & CPST_SW_USER_BITS);
      end
    end else if (cc_we) begin
      sw_q[CPST_SW_C] <= cc_in[0];
      sw_q[CPST_SW_V] <= cc_in[1];
      sw_q[CPST_SW_Z] <= cc_in[2];
      sw_q[CPST_SW_N] <= cc_in[3];
      sw_q[CPST_SW_X] <= cc_in[4];
    end
  end

  // ************************************************************
  // Interrupt level compare
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_sync1_q <= 3'h0;
      irq_lvl_q <= 3'h0;
    end else begin
      irq_sync1_q <= irq_level;
      irq_lvl_q <= irq_sync1_q;
    end
  end

  assign irq_take = (irq_lvl_q == 3'h7) || (irq_lvl_q > prio_mask);

  // ************************************************************
  // Operand read and address calculation
  // ************************************************************
  logic [31:0] rd_word;
  assign rd_word = gregs_q[bank(core_ridx, supervisor)];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_operand <= 32'h0000_0000;
    end else begin
      case (core_dtype)
        CPST_DT_BIT: core_operand <= {31'h00000000, rd_word[core_sel]};
        CPST_DT_BCD: core_operand <= {28'h0000000, rd_word[core_sel[2:0]*4 +: 4]};
        CPST_DT_BYTE: core_operand <= {24'h000000, rd_word[7:0]};
        CPST_DT_WORD: core_operand <= {16'h0000, rd_word[15:0]};
        default: core_operand <= rd_word;
      endcase
    end
  end

  assign ea.mode = ea_mode;
  assign ea.size = core_size;
  assign ea.base = gregs_q[bank(ea_base_idx, supervisor)];
  assign ea.index = gregs_q[bank(ea_index_idx, supervisor)];
  assign ea.index_long = ea_index_long;
  assign ea.disp = ea_disp;
  assign ea.pc = pc_q;
  assign ea.ext = ea_ext;
  assign ea.large_cfg = large_cfg_q;

  cpst_ea_calc u_calc (
    .ea(ea.calc)
  );

  ea_postinc_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ea_mode == CPST_AM_POSTINC |-> ea.base_wr && (ea.base_new - ea.base) inside
      {32'h0000_0001, 32'h0000_0002, 32'h0000_0004}) else $error("Postincrement step wrong");

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ea_addr <= 32'h0000_0000;
    end else if (ea_go) begin
      ea_addr <= ea.addr;
    end
  end

  assign pc = pc_q;
  assign status_word = sw_q;
  assign active_stack_pointer = gregs_q[bank(CPST_ACT_PTR_IDX, supervisor)];

  // ************************************************************
  // Assertions
  // ************************************************************
  sup_guard_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !supervisor |=> $stable(gregs_q[CPST_SUP_PTR_IDX]))
    else $error("Supervisor pointer changed in user state");
  sp_select_a: assert property (@(posedge hclk) disable iff (!hresetn)
    active_stack_pointer == (supervisor ? gregs_q[CPST_SUP_PTR_IDX]
                                        : gregs_q[CPST_USR_PTR_IDX]))
    else $error("Wrong stack pointer bank");
  nmi_take_a: assert property (@(posedge hclk) disable iff (!hresetn)
    irq_lvl_q == 3'h7 |-> irq_take) else $error("Level seven not taken");
  irq_mask_a: assert property (@(posedge hclk) disable iff (!hresetn)
    irq_lvl_q != 3'h7 && irq_lvl_q <= prio_mask |-> !irq_take)
    else $error("Masked level taken");
  irq_path_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ##2 irq_lvl_q == $past(irq_level, 2)) else $error("Level pipe broken");
  addr_width_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !large_cfg_q |-> ea.addr[31:CPST_ADDR_SMALL_W] == '0)
    else $error("Upper address lines driven");
  user_sw_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !supervisor && !cc_we |=> (sw_q & ~CPST_SW_USER_BITS) ==
      ($past(sw_q) & ~CPST_SW_USER_BITS)) else $error("System byte changed in user state");
  byte_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    core_we && core_size == CPST_SZ_BYTE && wr_idx < 5'h08 && !(ea.base_wr && ea_go)
    |=> gregs_q[$past(wr_idx)][31:8] == $past(wr_old[31:8]))
    else $error("Byte write disturbed upper bits");
endmodule

// File: test/tb_top.sv
/*
  Self-checking bench of the programmer state file: bus, core, address and
  interrupt ports are driven directly with no partner model.
  Assumes zero wait state AHB-Lite answers and registered core outputs.
*/
`timescale 1ns/1ps
module tb_top;
  import cpst_pkg::*;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, core_we = 1'b0, cc_we = 1'b0, pc_we = 1'b0, ea_go = 1'b0;
  logic ea_index_long = 1'b1, irq_take;
  logic [4:0] core_idx = 5'h0, core_ridx = 5'h0, core_sel = 5'h0, cc_in = 5'h0;
  logic [4:0] ea_base_idx = 5'h08, ea_index_idx = 5'h03;
  cpst_size_t core_size = CPST_SZ_LONG;
  cpst_dtype_t core_dtype = CPST_DT_LONG;
  cpst_amode_t ea_mode = CPST_AM_IND;
  logic [31:0] core_wdata = 32'h0, core_operand, pc_in = 32'h0, ea_ext = 32'h0, ea_addr;
  logic [31:0] pc, active_stack_pointer, rd;
  logic [15:0] ea_disp = 16'h0, status_word;
  logic [2:0] irq_level = 3'h0;
  int bad_count = 0, compares = 0;

  assign hready = hreadyout;
  always #2 hclk = ~hclk;

  cpst_state_file dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .core_we(core_we),
    .core_idx(core_idx), .core_size(core_size), .core_wdata(core_wdata),
    .core_ridx(core_ridx), .core_dtype(core_dtype), .core_sel(core_sel),
    .core_operand(core_operand), .cc_we(cc_we), .cc_in(cc_in), .pc_we(pc_we),
    .pc_in(pc_in), .ea_mode(ea_mode), .ea_base_idx(ea_base_idx),
    .ea_index_idx(ea_index_idx), .ea_index_long(ea_index_long), .ea_disp(ea_disp),
    .ea_ext(ea_ext), .ea_go(ea_go), .ea_addr(ea_addr), .irq_level(irq_level),
    .irq_take(irq_take), .pc(pc), .status_word(status_word),
    .active_stack_pointer(active_stack_pointer));

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, ofs};
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    check("bus response", {31'h0, hresp}, 32'h0);
    hsel <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] ofs, input logic [31:0] exp);
    bus(1'b0, ofs, 32'h0);
    check(what, rd, exp);
  endtask

  task automatic core_wr(input logic [4:0] idx, input cpst_size_t sz, input logic [31:0] d);
    @(posedge hclk);
    core_we <= 1'b1;
    core_idx <= idx;
    core_size <= sz;
    core_wdata <= d;
    @(posedge hclk);
    core_we <= 1'b0;
  endtask

  task automatic operand(input cpst_dtype_t t, input logic [4:0] sel, input logic [31:0] exp);
    @(posedge hclk);
    core_ridx <= 5'h01;
    core_dtype <= t;
    core_sel <= sel;
    repeat (2) @(posedge hclk);
    #1 check("operand", core_operand, exp);
  endtask

  task automatic ea_run(input cpst_amode_t m, input logic [15:0] d, input logic [31:0] e,
                        input logic [31:0] exp);
    @(posedge hclk);
    ea_mode <= m;
    ea_disp <= d;
    ea_ext <= e;
    ea_go <= 1'b1;
    @(posedge hclk);
    ea_go <= 1'b0;
    #1 check("effective address", ea_addr, exp);
  endtask

  task automatic do_reset();
    hresetn <= 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
  endtask

  // ************************************************************
  // Watchdog
  // ************************************************************
  initial begin
    repeat (20000) @(posedge hclk);
    bad_count++;
    complete_run();
  end

  // ************************************************************
  // Test sequence
  // ************************************************************
  initial begin
    logic [31:0] exp;
    do_reset();
    rd_chk("status reset", CPST_OFS_SW, 32'h2700);
    rd_chk("counter reset", CPST_OFS_PC, 32'h0);
    for (int i = 0; i < 17; i++) begin
      bus(1'b1, 8'(i * 4), 32'ha5000000 | 32'(i * 32'h01010101));
    end
    for (int i = 0; i < 17; i++) begin
      rd_chk("general reg", 8'(i * 4), 32'ha5000000 | 32'(i * 32'h01010101));
    end
    bus(1'b1, 8'h58, 32'hffff_ffff);
    rd_chk("status after unmapped", CPST_OFS_SW, 32'h2700);
    // Banked pointers
    bus(1'b1, 8'h40, 32'h5000);
    bus(1'b1, 8'h3c, 32'h3000);
    rd_chk("active pointer priv", CPST_OFS_ACT, 32'h5000);
    check("active port", active_stack_pointer, 32'h5000);
    bus(1'b1, CPST_OFS_ACT, 32'hdead);
    rd_chk("read only pointer", 8'h40, 32'h5000);
    bus(1'b1, CPST_OFS_SW, 32'h0);
    rd_chk("active pointer user", CPST_OFS_ACT, 32'h3000);
    bus(1'b1, 8'h40, 32'h7777);
    core_wr(CPST_SUP_PTR_IDX, CPST_SZ_LONG, 32'h8888);
    ea_base_idx <= CPST_SUP_PTR_IDX;
    ea_run(CPST_AM_POSTINC, 16'h0, 32'h0, 32'h5000);
    ea_base_idx <= 5'h08;
    rd_chk("protected pointer", 8'h40, 32'h5000);
    bus(1'b1, CPST_OFS_SW, 32'h271f);
    rd_chk("user byte only", CPST_OFS_SW, 32'h001f);
    check("status port", {16'h0, status_word}, 32'h001f);
    // Core sizes and flags
    do_reset();
    bus(1'b1, 8'h00, 32'h11223344);
    core_wr(5'h00, CPST_SZ_BYTE, 32'h000000aa);
    core_wr(5'h02, CPST_SZ_WORD, 32'h0000beef);
    rd_chk("data byte", 8'h00, 32'h112233aa);
    rd_chk("data word", 8'h08, 32'h0000beef);
    bus(1'b1, 8'h24, 32'h11223344);
    core_wr(5'h09, CPST_SZ_BYTE, 32'h000000aa);
    rd_chk("addr byte ignored", 8'h24, 32'h11223344);
    core_wr(5'h09, CPST_SZ_WORD, 32'h00008001);
    rd_chk("addr word", 8'h24, 32'hffff8001);
    @(posedge hclk);
    cc_we <= 1'b1;
    cc_in <= 5'h15;
    @(posedge hclk);
    cc_we <= 1'b0;
    rd_chk("condition flags", CPST_OFS_SW, 32'h2715);
    // Operand types
    bus(1'b1, 8'h04, 32'h12345678);
    operand(CPST_DT_BIT, 5'd3, 32'h1);
    operand(CPST_DT_BCD, 5'd2, 32'h6);
    operand(CPST_DT_BYTE, 5'd0, 32'h78);
    operand(CPST_DT_WORD, 5'd0, 32'h5678);
    operand(CPST_DT_LONG, 5'd0, 32'h12345678);
    // Address calculation
    bus(1'b1, 8'h20, 32'h1000);
    bus(1'b1, 8'h0c, 32'h20);
    @(posedge hclk);
    pc_we <= 1'b1;
    pc_in <= 32'h4000;
    @(posedge hclk);
    pc_we <= 1'b0;
    core_size <= CPST_SZ_LONG;
    ea_run(CPST_AM_IND, 16'h0, 32'h0, 32'h1000);
    check("counter port", pc, 32'h4000);
    ea_run(CPST_AM_DISP, 16'hfffc, 32'h0, 32'h0ffc);
    ea_run(CPST_AM_INDEX, 16'h0010, 32'h0, 32'h1030);
    ea_run(CPST_AM_PC_DISP, 16'h0100, 32'h0, 32'h4100);
    ea_run(CPST_AM_PC_INDEX, 16'h0010, 32'h0, 32'h4030);
    ea_run(CPST_AM_ABS_L, 16'h0, 32'h00012340, 32'h00012340);
    ea_run(CPST_AM_POSTINC, 16'h0, 32'h0, 32'h1000);
    rd_chk("postincrement base", 8'h20, 32'h1004);
    ea_run(CPST_AM_PREDEC, 16'h0, 32'h0, 32'h1000);
    rd_chk("predecrement base", 8'h20, 32'h1000);
    core_size <= CPST_SZ_WORD;
    ea_run(CPST_AM_PREDEC, 16'h0, 32'h0, 32'h0ffe);
    rd_chk("word predecrement base", 8'h20, 32'h0ffe);
    ea_run(CPST_AM_ABS_L, 16'h0, 32'h00fffff0, 32'h000ffff0);
    ea_run(CPST_AM_ABS_W, 16'h8010, 32'h0, 32'h000f8010);
    bus(1'b1, CPST_OFS_CFG, 32'h1);
    ea_run(CPST_AM_ABS_L, 16'h0, 32'h00fffff0, 32'h003ffff0);
    // Interrupt mask
    for (int m = 0; m < 8; m++) begin
      bus(1'b1, CPST_OFS_SW, 32'h2000 | 32'(m << 8));
      for (int l = 0; l < 8; l++) begin
        @(posedge hclk);
        irq_level <= 3'(l);
        repeat (4) @(posedge hclk);
        exp = ((l > m) || (l == 7)) ? 32'h1 : 32'h0;
        #1 check("interrupt take", {31'h0, irq_take}, exp);
      end
    end
    rd_chk("interrupt reg", CPST_OFS_IRQ, 32'hf);
    complete_run();
  end
endmodule
